/* File: rtl/dmc_channel.sv */
// one dma channel: registers, transfer sequencer, block reload
`timescale 1ns/1ns
`include "dmc_regs.svh"
module dmc_channel
  import dmc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [4:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic         hw_request_line,
  input  wire logic         prio_hold,
  input  wire logic         other_on,
  output logic              chan_req,
  output logic              bus_own,
  output dmc_mem_req_t      mem_req,
  input  wire logic         mem_ack,
  input  wire logic [15:0]  mem_rdata,
  output logic              irq,
  output logic              dma_clk_en
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic [1:0]  sel);
    case (sel)
      `DMC_STEP_INC1: step_addr = a + 24'h00_0001;
      `DMC_STEP_INC2: step_addr = a + 24'h00_0002;
      `DMC_STEP_DEC1: step_addr = a - 24'h00_0001;
      default:        step_addr = a - 24'h00_0002;
    endcase
  endfunction : step_addr

  function automatic logic [15:0] fix_len(input logic [15:0] v);
    fix_len = (v == `DMC_LEN_ZERO) ? `DMC_LEN_MAX : v;
  endfunction : fix_len

  ////////////////////////////////////////////////////////////////////////
  logic [23:0]  a_ctr_r;
  logic [23:0]  a_start_r;
  logic [23:0]  b_ctr_r;
  logic [23:0]  b_start_r;
  logic [15:0]  len_ctr_r;
  logic [15:0]  len_rel_r;
  logic [15:0]  ctrl_r;
  logic         tc_r;
  logic         ovr_r;
  logic         vld_r;
  logic         run_r;
  logic [15:0]  hold_r;
  logic         hw_s1_r;
  logic         hw_s2_r;
  dmc_state_t   state_r;
  dmc_state_t   state_nxt;

  logic         on_b;
  logic         copy_b;
  logic         dir_b;
  logic         auto_b;
  logic         burst_b;
  logic         busy;
  logic         req;
  logic         go;
  logic         xfer_done;
  logic         blk_end;
  logic         blk_cont;
  logic         w_a_ctr;
  logic         w_a_start;
  logic         w_b_ctr;
  logic         w_b_start;
  logic         w_len_ctr;
  logic         w_len_rel;
  logic         w_ctrl;
  logic         w_stat;
  logic [15:0]  len_dec;

  assign on_b    = ctrl_r[`DMC_CT_ON];
  assign copy_b  = ctrl_r[`DMC_CT_COPY];
  assign dir_b   = ctrl_r[`DMC_CT_DIR];
  assign auto_b  = ctrl_r[`DMC_CT_RELOAD];
  assign burst_b = ctrl_r[`DMC_CT_BURST];

  assign w_a_ctr   = reg_wr && reg_addr == `DMC_OFS_A_CTR;
  assign w_a_start = reg_wr && reg_addr == `DMC_OFS_A_START;
  assign w_b_ctr   = reg_wr && reg_addr == `DMC_OFS_B_CTR;
  assign w_b_start = reg_wr && reg_addr == `DMC_OFS_B_START;
  assign w_len_ctr = reg_wr && reg_addr == `DMC_OFS_LEN_CTR;
  assign w_len_rel = reg_wr && reg_addr == `DMC_OFS_LEN_REL;
  assign w_ctrl    = reg_wr && reg_addr == `DMC_OFS_CTRL;
  assign w_stat    = reg_wr && reg_addr == `DMC_OFS_STAT;

  assign busy = on_b && len_ctr_r != `DMC_LEN_ZERO;
  // soft request simply ors in; software avoids it while hw is busy
  assign req  = hw_s2_r || ctrl_r[`DMC_CT_SOFT];
  assign chan_req = run_r && req;
  // lower channels hold us off only at a cycle boundary
  assign go = (state_r == DMC_IDLE) && chan_req && !prio_hold;
  assign xfer_done = mem_ack &&
                     ((state_r == DMC_PH2) || (state_r == DMC_PH1 && !copy_b));
  assign len_dec  = len_ctr_r - `DMC_LEN_ONE;
  assign blk_end  = xfer_done && len_dec == `DMC_LEN_ZERO;
  assign blk_cont = auto_b || vld_r;
  assign irq = (tc_r && ctrl_r[`DMC_CT_CNT_IE]) ||
               (ovr_r && ctrl_r[`DMC_CT_OVR_IE]);
  assign dma_clk_en = on_b || other_on;

  ////////////////////////////////////////////////////////////////////////
  // request pin is asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hw_s1_r <= 1'b0;
      hw_s2_r <= 1'b0;
    end else begin
      hw_s1_r <= hw_request_line;
      hw_s2_r <= hw_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DMC_IDLE: begin
        if (go) begin
          state_nxt = DMC_PH1;
        end
      end
      DMC_PH1: begin
        if (mem_ack) begin
          state_nxt = copy_b ? DMC_PH2 : DMC_GAP;
        end
      end
      DMC_PH2: begin
        if (mem_ack) begin
          state_nxt = DMC_GAP;
        end
      end
      default: begin
        state_nxt = DMC_IDLE;
      end
    endcase
    // burst keeps the bus while the request stands
    if (xfer_done && burst_b && req && !(blk_end && !blk_cont) && on_b) begin
      state_nxt = DMC_PH1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= DMC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus_own = (state_r == DMC_PH1) || (state_r == DMC_PH2);

  always_comb begin
    mem_req       = '0;
    mem_req.valid = bus_own;
    mem_req.word  = ctrl_r[`DMC_CT_SIZE];
    mem_req.flyby = !copy_b;
    mem_req.wdata = hold_r;
    if (!copy_b) begin
      mem_req.addr  = a_ctr_r;
      mem_req.write = dir_b;
    end else if (state_r == DMC_PH1) begin
      mem_req.addr  = dir_b ? b_ctr_r : a_ctr_r;
      mem_req.write = 1'b0;
    end else begin
      mem_req.addr  = dir_b ? a_ctr_r : b_ctr_r;
      mem_req.write = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_r <= 16'h0000;
    end else if (state_r == DMC_PH1 && mem_ack && copy_b) begin
      hold_r <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r <= `DMC_CTRL_RST;
    end else if (w_ctrl) begin
      ctrl_r <= reg_wdata[15:0];
    end
  end

  // a write of one restarts even when already on
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
    end else if (w_ctrl) begin
      run_r <= reg_wdata[`DMC_CT_ON];
    end else if (blk_end && !blk_cont) begin
      run_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      a_start_r <= `DMC_ADDR_RST;
      b_start_r <= `DMC_ADDR_RST;
      len_rel_r <= `DMC_LEN_RST;
    end else begin
      if (w_a_start) begin
        a_start_r <= reg_wdata[23:0];
      end
      if (w_b_start) begin
        b_start_r <= reg_wdata[23:0];
      end
      if (w_len_rel) begin
        len_rel_r <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      a_ctr_r <= `DMC_ADDR_RST;
    end else if (w_a_ctr) begin
      a_ctr_r <= reg_wdata[23:0];
    end else if (blk_end && blk_cont) begin
      a_ctr_r <= a_start_r;
    end else if (xfer_done && ctrl_r[`DMC_CT_A_EN]) begin
      a_ctr_r <= step_addr(a_ctr_r, ctrl_r[`DMC_CT_A_SEL_LO +: 2]);
    end
  end

  // flyby never touches the B pair
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      b_ctr_r <= `DMC_ADDR_RST;
    end else if (w_b_ctr) begin
      b_ctr_r <= reg_wdata[23:0];
    end else if (copy_b && blk_end && blk_cont) begin
      b_ctr_r <= b_start_r;
    end else if (copy_b && xfer_done && ctrl_r[`DMC_CT_B_EN]) begin
      b_ctr_r <= step_addr(b_ctr_r, ctrl_r[`DMC_CT_B_SEL_LO +: 2]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len_ctr_r <= `DMC_LEN_RST;
    end else if (w_len_ctr) begin
      len_ctr_r <= reg_wdata[15:0];
    // only an exhausted counter is revived, so a restart never eats a decrement
    end else if (w_ctrl && reg_wdata[`DMC_CT_ON] && len_ctr_r == `DMC_LEN_ZERO) begin
      len_ctr_r <= fix_len(len_ctr_r);
    end else if (blk_end && blk_cont) begin
      len_ctr_r <= fix_len(len_rel_r);
    end else if (xfer_done) begin
      len_ctr_r <= len_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tc_r <= 1'b0;
    end else if (blk_end) begin
      tc_r <= 1'b1;
    end else if (w_stat && reg_wdata[`DMC_ST_TC]) begin
      tc_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovr_r <= 1'b0;
    end else if (blk_end && (auto_b ? tc_r : !vld_r)) begin
      ovr_r <= 1'b1;
    end else if (w_stat && reg_wdata[`DMC_ST_OVR]) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vld_r <= 1'b0;
    end else if (w_len_rel) begin
      vld_r <= 1'b1;
    end else if (blk_end && blk_cont) begin
      vld_r <= 1'b0;
    end else if (w_stat && reg_wdata[`DMC_ST_VLD]) begin
      vld_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unmapped offsets read as zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DMC_OFS_A_CTR:   reg_rdata <= {`DMC_UPPER_ZERO, a_ctr_r};
        `DMC_OFS_A_START: reg_rdata <= {`DMC_UPPER_ZERO, a_start_r};
        `DMC_OFS_B_CTR:   reg_rdata <= {`DMC_UPPER_ZERO, b_ctr_r};
        `DMC_OFS_B_START: reg_rdata <= {`DMC_UPPER_ZERO, b_start_r};
        `DMC_OFS_LEN_CTR: reg_rdata <= {16'h0000, len_ctr_r};
        `DMC_OFS_LEN_REL: reg_rdata <= {16'h0000, len_rel_r};
        `DMC_OFS_CTRL:    reg_rdata <= {16'h0000, ctrl_r};
        `DMC_OFS_STAT:    reg_rdata <= {24'h00_0000, `DMC_STAT_PAD,
                                        vld_r, busy, ovr_r, tc_r};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking dmc_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence copy_read_s;
    state_r == DMC_PH1 && copy_b && mem_ack && !mem_req.write;
  endsequence
  sequence copy_write_s;
    state_r == DMC_PH2 ##0 mem_req.write;
  endsequence

  upper_zero_a: assert property (reg_rd && reg_addr == `DMC_OFS_B_CTR
    |=> reg_rdata[31:24] == 8'h00 && reg_rdata[23:0] == $past(b_ctr_r))
    else $error("b counter read back wrong");
  len_count_a: assert property (xfer_done && !blk_end && !w_len_ctr
    |=> len_ctr_r == $past(len_ctr_r) - 16'h0001)
    else $error("length counter did not drop by one");
  flyby_b_a: assert property (!copy_b && !w_b_ctr
    |=> $stable(b_ctr_r))
    else $error("b counter moved in flyby");
  vld_set_a: assert property (w_len_rel |=> vld_r ##1 (vld_r ||
    $past(blk_end && blk_cont) || $past(w_stat && reg_wdata[`DMC_ST_VLD])))
    else $error("valid flag not set by reload write");
  tc_set_a: assert property (blk_end |=> tc_r)
    else $error("count flag missing at block end");
  buf_ovr_a: assert property (blk_end && !auto_b && !vld_r && !w_ctrl
    |=> ovr_r && !run_r ##1 state_r == DMC_IDLE)
    else $error("buffered overrun or stop wrong");
  auto_ovr_a: assert property (blk_end && auto_b && tc_r && !w_len_ctr
    |=> ovr_r && len_ctr_r == fix_len($past(len_rel_r)))
    else $error("auto reload or overrun wrong");
  gap_bus_a: assert property (xfer_done && !burst_b |=> !bus_own ##1 !bus_own)
    else $error("intermittent mode kept the bus");
  a_step_a: assert property (xfer_done && ctrl_r[`DMC_CT_A_EN] && !blk_end && !w_a_ctr
    && ctrl_r[`DMC_CT_A_SEL_LO +: 2] == `DMC_STEP_DEC2
    |=> a_ctr_r == $past(a_ctr_r) - 24'h00_0002)
    else $error("a counter step wrong");
  restart_a: assert property (w_ctrl && reg_wdata[`DMC_CT_ON] |=> run_r)
    else $error("channel did not restart");
  copy_seq_a: assert property (copy_read_s |=> copy_write_s)
    else $error("copy write phase did not follow read");
  prio_a: assert property (state_r == DMC_IDLE && prio_hold |=> state_r != DMC_PH1)
    else $error("started while lower channel pending");

endmodule : dmc_channel

/* File: common/dmc_regs.svh */
// register offsets, field positions and reset values of the channel
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_OFS_A_CTR    5'h00
`define DMC_OFS_A_START  5'h04
`define DMC_OFS_B_CTR    5'h08
`define DMC_OFS_B_START  5'h0c
`define DMC_OFS_LEN_CTR  5'h10
`define DMC_OFS_LEN_REL  5'h14
`define DMC_OFS_CTRL     5'h1c
`define DMC_OFS_STAT     5'h1e
`define DMC_CT_ON        0
`define DMC_CT_CNT_IE    1
`define DMC_CT_OVR_IE    2
`define DMC_CT_SIZE      3
`define DMC_CT_COPY      4
`define DMC_CT_DIR       5
`define DMC_CT_RELOAD    6
`define DMC_CT_BURST     7
`define DMC_CT_SOFT      8
`define DMC_CT_A_EN      9
`define DMC_CT_A_SEL_LO  10
`define DMC_CT_B_EN      12
`define DMC_CT_B_SEL_LO  13
`define DMC_ST_TC        0
`define DMC_ST_OVR       1
`define DMC_ST_BUSY      2
`define DMC_ST_VLD       3
`define DMC_CTRL_RST     16'h0000
`define DMC_ADDR_RST     24'h00_0000
`define DMC_LEN_RST      16'h0000
`define DMC_LEN_ZERO     16'h0000
`define DMC_LEN_MAX      16'hffff
`define DMC_LEN_ONE      16'h0001
`define DMC_UPPER_ZERO   8'h00
`define DMC_STAT_PAD     4'h0
`define DMC_STEP_INC1    2'b00
`define DMC_STEP_INC2    2'b01
`define DMC_STEP_DEC1    2'b10
`define DMC_STEP_DEC2    2'b11
`endif

/* File: common/dmc_pkg.sv */
// types shared by the channel and its bench
package dmc_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        flyby;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } dmc_mem_req_t;
  typedef enum logic [1:0] {
    DMC_IDLE  = 2'b00,
    DMC_PH1   = 2'b01,
    DMC_PH2   = 2'b10,
    DMC_GAP   = 2'b11
  } dmc_state_t;
endpackage : dmc_pkg

/* File: tb/dmc_mem_model.sv */
// memory bus responder standing at the far side of the channel
`timescale 1ns/1ns
module dmc_mem_model
  import dmc_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire dmc_mem_req_t  mem_req,
  input  wire logic [3:0]    lat,
  output logic               mem_ack,
  output logic [15:0]        mem_rdata,
  output int                 phases,
  output logic [23:0]        last_addr,
  output logic               last_write,
  output logic [15:0]        last_wdata,
  output logic [15:0]        last_rdata
);
  logic [3:0]  wait_r;
  logic [15:0] data_r;
  // released bus shows inverted data, never a stale value
  assign mem_rdata = mem_ack ? data_r : ~data_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_r <= 4'h0;
      mem_ack <= 1'b0;
      data_r <= 16'h0000;
      phases <= 0;
      last_addr <= 24'h00_0000;
      last_write <= 1'b0;
      last_wdata <= 16'h0000;
      last_rdata <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req.valid && !mem_ack) begin
        if (wait_r >= lat) begin
          mem_ack <= 1'b1;
          wait_r <= 4'h0;
          phases <= phases + 1;
          last_addr <= mem_req.addr;
          last_write <= mem_req.write;
          if (mem_req.write) begin
            last_wdata <= mem_req.wdata;
          end else begin
            data_r <= {mem_req.addr[7:0], ~mem_req.addr[7:0]};
            last_rdata <= {mem_req.addr[7:0], ~mem_req.addr[7:0]};
          end
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule : dmc_mem_model

/* File: tb/tb_top.sv */
// self-checking bench for one dma channel
`timescale 1ns/1ns
`include "dmc_regs.svh"
module tb_top
  import dmc_pkg::*;
;
  logic         sys_clk, sys_rst, reg_wr, reg_rd, hw_request_line, prio_hold, other_on;
  logic         chan_req, bus_own, mem_ack, irq, dma_clk_en, last_write, prev_own;
  logic         dir, cp, bu, sz;
  logic [1:0]   sa, sb;
  logic [3:0]   lat;
  logic [4:0]   reg_addr;
  logic [15:0]  mem_rdata, last_wdata, last_rdata, mk;
  logic [23:0]  a0, b0, last_addr, ea;
  logic [31:0]  reg_wdata, reg_rdata, seed, rv, dv;
  dmc_mem_req_t mem_req;
  int           miscompares, cmp_count, phases, ph0, rel, n, i, k;

  dmc_channel dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_request_line(hw_request_line), .prio_hold(prio_hold), .other_on(other_on),
    .chan_req(chan_req), .bus_own(bus_own), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq(irq), .dma_clk_en(dma_clk_en));
  dmc_mem_model mem_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req(mem_req), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .phases(phases), .last_addr(last_addr),
    .last_write(last_write), .last_wdata(last_wdata), .last_rdata(last_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // counts bus releases, sampled away from the launching edge
  always @(negedge sys_clk) begin
    if (prev_own === 1'b1 && bus_own === 1'b0) rel++;
    prev_own = bus_own;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [23:0] adv(input logic [23:0] b, input logic [1:0] s,
                                      input logic [23:0] c);
    logic [23:0] st;
    st = (s == 2'b00) ? 24'h1 : (s == 2'b01) ? 24'h2 : (s == 2'b10) ? 24'hffffff : 24'hfffffe;
    return b + c * st;
  endfunction : adv
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rchk
  // always polls at least once: read data is zero between reads
  task automatic wait_idle();
    i = 0;
    do begin
      @(posedge sys_clk);
      reg_addr <= `DMC_OFS_STAT;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      i++;
    end while (i < 300 && reg_rdata[`DMC_ST_BUSY] !== 1'b0);
    chk("idle wait", 32'h0, {31'h0, reg_rdata[`DMC_ST_BUSY]});
  endtask : wait_idle
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    seed = 32'h069d14e1;
    sys_rst <= 1'b1;
    {reg_wr, reg_rd, hw_request_line, prio_hold, other_on} <= 5'h00;
    reg_addr <= 5'h00;
    reg_wdata <= 32'h0;
    lat <= 4'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`DMC_OFS_CTRL, 32'h0, "control reset");
    rchk(`DMC_OFS_STAT, 32'h0, "status reset");
    chk("clock gate off", 32'h0, {31'h0, dma_clk_en});
    // address registers keep 24 bits whatever is written above them
    for (k = 0; k < 4; k++) begin
      rv = xs();
      wr(5'(4 * k), rv);
      rchk(5'(4 * k), {8'h00, rv[23:0]}, "address width");
    end
    wr(5'h18, 32'hffffffff);
    rchk(5'h18, 32'h0, "unmapped");
    wr(`DMC_OFS_LEN_REL, 32'h5);
    rchk(`DMC_OFS_STAT, 32'h8, "valid on reload write");
    wr(`DMC_OFS_STAT, 32'h8);
    rchk(`DMC_OFS_STAT, 32'h0, "valid cleared");
    // random single blocks over all step codes, both transfer types
    for (k = 0; k < 8; k++) begin
      rv = xs();
      a0 = rv[23:0];
      dv = xs();
      b0 = dv[23:0];
      n = int'(rv[25:24]) + 1;
      {dir, sz, bu, cp} = {dv[31], k[0], k[1], k[2]};
      sa = k[1:0];
      sb = ~k[1:0];
      mk = sz ? 16'hffff : 16'h00ff;
      lat <= {2'b00, dv[25:24]};
      wr(`DMC_OFS_A_CTR, {8'h00, a0});
      wr(`DMC_OFS_B_CTR, {8'h00, b0});
      wr(`DMC_OFS_LEN_CTR, n);
      ph0 = phases;
      rel = 0;
      dv = {17'h0, sb, 1'b1, sa, 2'b11, bu, 1'b0, dir, cp, sz, 3'b011};
      wr(`DMC_OFS_CTRL, dv);
      wait_idle();
      rchk(`DMC_OFS_A_CTR, adv(a0, sa, 24'(n)), "a counter");
      ea = cp ? adv(b0, sb, 24'(n)) : b0;
      rchk(`DMC_OFS_B_CTR, {8'h00, ea}, "b counter");
      rchk(`DMC_OFS_LEN_CTR, 32'h0, "length counter");
      rchk(`DMC_OFS_STAT, 32'h3, "block end flags");
      chk("phases", cp ? 2 * n : n, phases - ph0);
      chk("releases", bu ? 1 : n, rel);
      chk("last write", cp | dir, last_write);
      ea = (cp && !dir) ? adv(b0, sb, 24'(n - 1)) : adv(a0, sa, 24'(n - 1));
      chk("last addr", {8'h00, ea}, {8'h00, last_addr});
      if (cp) chk("copy data", last_rdata & mk, last_wdata & mk);
      chk("count irq", 32'h1, irq);
      wr(`DMC_OFS_STAT, 32'h0);
      rchk(`DMC_OFS_STAT, 32'h3, "write zero");
      wr(`DMC_OFS_STAT, 32'hf);
      wr(`DMC_OFS_CTRL, 32'h0);
      rchk(`DMC_OFS_STAT, 32'h0, "flags cleared");
      chk("irq cleared", 32'h0, irq);
    end
    // zero length, held off by a higher channel, request withdrawn
    prio_hold <= 1'b1;
    wr(`DMC_OFS_LEN_CTR, 32'h0);
    wr(`DMC_OFS_CTRL, 32'h0101);
    rchk(`DMC_OFS_LEN_CTR, 32'hffff, "zero length");
    rchk(`DMC_OFS_STAT, 32'h4, "busy");
    chk("request up", 32'h1, chan_req);
    chk("held off", 32'h0, bus_own);
    chk("clock gate on", 32'h1, dma_clk_en);
    wr(`DMC_OFS_CTRL, 32'h0001);
    // let the control register settle past the launching edge
    #1;
    chk("request down", 32'h0, chan_req);
    wr(`DMC_OFS_CTRL, 32'h0);
    prio_hold <= 1'b0;
    other_on <= 1'b1;
    rchk(`DMC_OFS_STAT, 32'h0, "disabled");
    chk("other on", 32'h1, dma_clk_en);
    other_on <= 1'b0;
    // double buffer driven by the hardware request, bus policy left clear
    wr(`DMC_OFS_A_CTR, 32'h100);
    wr(`DMC_OFS_A_START, 32'h800);
    wr(`DMC_OFS_LEN_CTR, 32'h2);
    wr(`DMC_OFS_LEN_REL, 32'h3);
    ph0 = phases;
    wr(`DMC_OFS_CTRL, 32'h0201);
    hw_request_line <= 1'b1;
    wait_idle();
    hw_request_line <= 1'b0;
    chk("two blocks", 5, phases - ph0);
    rchk(`DMC_OFS_A_CTR, 32'h803, "reloaded a");
    rchk(`DMC_OFS_STAT, 32'h3, "second block end");
    wr(`DMC_OFS_CTRL, 32'h0);
    wr(`DMC_OFS_STAT, 32'hf);
    // auto-initialize repeats until the request goes away
    wr(`DMC_OFS_A_CTR, 32'h400);
    wr(`DMC_OFS_A_START, 32'h400);
    wr(`DMC_OFS_LEN_CTR, 32'h2);
    wr(`DMC_OFS_LEN_REL, 32'h2);
    ph0 = phases;
    wr(`DMC_OFS_CTRL, 32'h0245);
    hw_request_line <= 1'b1;
    for (i = 0; i < 400 && phases - ph0 < 5; i++) @(posedge sys_clk);
    hw_request_line <= 1'b0;
    repeat (20) @(posedge sys_clk);
    n = (phases - ph0) % 2;
    rchk(`DMC_OFS_A_CTR, 32'h400 + n, "auto a");
    rchk(`DMC_OFS_LEN_CTR, 32'(2 - n), "auto length");
    // valid was used up by the first reload, channel still busy
    rchk(`DMC_OFS_STAT, 32'h7, "auto flags");
    chk("overrun irq", 32'h1, irq);
    wr(`DMC_OFS_CTRL, 32'h0);
    give_verdict();
  end
endmodule : tb_top
